/* src/cfbw_pkg.sv */
// Purpose: shared constants and types for the cipher feedback mode wrapper
// Assumes: 64-bit block cipher core with start/done handshake
// Notes: cbc mac chaining shares the core with the feedback path
package cfbw_pkg;
    // ==========================================================
    // block geometry
    localparam int BLOCK_W = 64;
    localparam int KW_W = 7;
    localparam logic [63:0] REG_RESET = 64'h0000000000000000;
    localparam logic [6:0] K_RESET = 7'h08;
    localparam logic [6:0] K_MAX = 7'h40;

    // ==========================================================
    // operation modes
    typedef enum logic [1:0]
    {
        CFBW_ENC,
        CFBW_DEC,
        CFBW_MAC_CFB,
        CFBW_MAC_CBC
    } cfbw_mode_t;
endpackage : cfbw_pkg

/* src/cfbw_shift.sv */
// Purpose: k-bit left shift of the cipher input register with feedback fill
// Assumes: 1 <= k <= 64
// Notes: purely combinational; bit 1 of the documented block is bit 63 here
module cfbw_shift
    import cfbw_pkg::*;
(
    // register and feedback
    input wire logic [63:0] reg_in,
    input wire logic [63:0] fb_in,
    input wire logic [6:0] k_in,
    // shifted result
    output logic [63:0] shifted_out
);
    logic [63:0] mask;

    // fb_in holds the character right aligned; mask keeps only its low k bits
    always_comb
    begin
        if (k_in >= K_MAX)
        begin
            mask = '1;
            shifted_out = fb_in;
        end
        else
        begin
            mask = (64'h0000000000000001 << k_in) - 64'h0000000000000001;
            shifted_out = (reg_in << k_in) | (fb_in & mask);
        end
    end
endmodule : cfbw_shift

/* src/cfbw_top.sv */
// Purpose: cipher feedback mode wrapper around a 64-bit block cipher core
// Assumes: core always runs forward; host holds request until accepted
// Notes: one character in flight; cbc mac needs k = 64 data blocks
module cfbw_top
    import cfbw_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // configuration
    input wire logic [1:0] mode_in,
    input wire logic [6:0] k_in,
    // starting vector load
    input wire logic sv_load_in,
    input wire logic [63:0] starting_vector_in,
    // character request
    input wire logic char_valid_in,
    input wire logic [63:0] char_data_in,
    input wire logic [6:0] char_width_in,
    input wire logic char_last_in,
    output logic char_ready_out,
    // result
    output logic res_valid_out,
    output logic [63:0] res_data_out,
    // mac check
    input wire logic [63:0] mac_expected_in,
    input wire logic [63:0] mid_received_in,
    input wire logic [63:0] mid_expected_in,
    output logic mac_done_out,
    output logic mac_ok_out,
    // cipher core
    output logic core_start_out,
    output logic [63:0] core_block_out,
    output logic core_decrypt_out,
    input wire logic core_done_in,
    input wire logic [63:0] core_result_in
);
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_RUN,
        ST_FINAL
    } cfbw_state_t;

    cfbw_state_t state_q;
    logic [63:0] sr_q;
    logic [63:0] data_q;
    logic last_q;
    logic [6:0] k_q;
    cfbw_mode_t mode_q;
    logic [63:0] kmask;
    logic [63:0] ext_data;
    logic [63:0] ks_bits;
    logic [63:0] xor_res;
    logic [63:0] fb_val;
    logic [63:0] shifted;
    logic is_mac;
    logic char_take;

    // ==========================================================
    // combinational datapath
    assign kmask = (k_q >= K_MAX) ? 64'hffffffffffffffff
        : ((64'h0000000000000001 << k_q) - 64'h0000000000000001);

    // width is 1..64; zero width treated as full
    assign ext_data = (char_width_in >= K_MAX || char_width_in == 7'h00) ? char_data_in
        : (char_data_in & ((64'h0000000000000001 << char_width_in)
        - 64'h0000000000000001));

    always_comb
    begin
        // leftmost k output bits brought to the low end, rest dropped
        ks_bits = (k_q >= K_MAX) ? core_result_in
            : ((core_result_in >> (7'h40 - k_q)) & kmask);
        xor_res = (data_q & kmask) ^ ks_bits;
        // decryption feeds back what arrived, not what came out
        fb_val = (mode_q == CFBW_DEC) ? data_q : xor_res;
    end

    cfbw_shift u_shift
    (
        .reg_in(sr_q),
        .fb_in(fb_val),
        .k_in(k_q),
        .shifted_out(shifted)
    );

    assign is_mac = (mode_q == CFBW_MAC_CFB) || (mode_q == CFBW_MAC_CBC);
    // gated by ready so that a request held high is taken exactly once
    assign char_take = (state_q == ST_IDLE) && char_ready_out && char_valid_in
        && !sv_load_in;

    // ==========================================================
    // sequencing
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_q <= ST_IDLE;
        end
        else if (sv_load_in)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (char_take)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (core_done_in)
                    begin
                        // feedback mac costs one more core pass
                        state_q <= (mode_q == CFBW_MAC_CFB && last_q) ? ST_FINAL
                            : ST_IDLE;
                    end
                end
                ST_FINAL:
                begin
                    if (core_done_in)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // captured request and configuration
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            data_q <= REG_RESET;
            last_q <= 1'b0;
            k_q <= K_RESET;
            mode_q <= CFBW_ENC;
        end
        else if (sv_load_in)
        begin
            k_q <= (k_in == 7'h00 || k_in > K_MAX) ? K_MAX : k_in;
            mode_q <= cfbw_mode_t'(mode_in);
        end
        else if (char_take)
        begin
            data_q <= ext_data;
            last_q <= char_last_in;
        end
    end

    // ==========================================================
    // cipher input register
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sr_q <= REG_RESET;
        end
        else if (sv_load_in)
        begin
            // whole register replaced; short vectors arrive zero filled on top
            sr_q <= starting_vector_in;
        end
        else if (state_q == ST_RUN && core_done_in)
        begin
            if (mode_q == CFBW_MAC_CBC)
            begin
                // chaining: next input is output xor next block (zero pad done by host)
                sr_q <= core_result_in;
            end
            else
            begin
                sr_q <= shifted;
            end
        end
    end

    // ==========================================================
    // core handshake
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            core_start_out <= 1'b0;
            core_block_out <= REG_RESET;
        end
        else if (char_take)
        begin
            core_start_out <= 1'b1;
            // cbc mac: first block is zero, so identifier alone is the input
            core_block_out <= (mode_q == CFBW_MAC_CBC) ? (sr_q ^ ext_data) : sr_q;
        end
        else if (state_q == ST_RUN && core_done_in && mode_q == CFBW_MAC_CFB
            && last_q)
        begin
            core_start_out <= 1'b1;
            core_block_out <= shifted;
        end
        else
        begin
            core_start_out <= 1'b0;
        end
    end

    // forward direction only, even for decryption: feedback never needs the inverse
    always_ff @(posedge clk_in)
    begin
        core_decrypt_out <= 1'b0;
    end

    // ==========================================================
    // host side results
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            char_ready_out <= 1'b0;
            res_valid_out <= 1'b0;
            res_data_out <= REG_RESET;
        end
        else
        begin
            // ready is set from the next state so it tracks the idle state with no lag; low on the taking edge
            char_ready_out <= sv_load_in || ((state_q == ST_IDLE) && !char_take)
                || (core_done_in && ((state_q == ST_FINAL) || ((state_q == ST_RUN)
                && !(mode_q == CFBW_MAC_CFB && last_q))));
            res_valid_out <= 1'b0;
            if (state_q == ST_RUN && core_done_in && !sv_load_in && !is_mac)
            begin
                res_valid_out <= 1'b1;
                res_data_out <= xor_res;
            end
            else if (!sv_load_in && core_done_in && ((state_q == ST_FINAL)
                || (state_q == ST_RUN && mode_q == CFBW_MAC_CBC && last_q)))
            begin
                // mac result; intermediate cipher never leaves
                res_valid_out <= 1'b1;
                res_data_out <= ks_bits;
            end
        end
    end

    // ==========================================================
    // mac comparison
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mac_done_out <= 1'b0;
            mac_ok_out <= 1'b0;
        end
        else if (!sv_load_in && core_done_in && ((state_q == ST_FINAL)
            || (state_q == ST_RUN && mode_q == CFBW_MAC_CBC && last_q)))
        begin
            mac_done_out <= 1'b1;
            mac_ok_out <= (ks_bits == (mac_expected_in & kmask))
                && (mid_received_in == mid_expected_in);
        end
        else
        begin
            mac_done_out <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    a_start_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        core_start_out |=> !core_start_out)
        else $error("core start longer than one cycle");
    a_forward_only: assert property (@(posedge clk_in) disable iff (reset_in)
        !core_decrypt_out)
        else $error("core driven in reverse direction");
    a_stall_busy: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q == ST_RUN) |-> !char_ready_out)
        else $error("host not stalled while core busy");
    a_vector_load: assert property (@(posedge clk_in) disable iff (reset_in)
        sv_load_in |=> (sr_q == $past(starting_vector_in)))
        else $error("starting vector not loaded");
    a_restart_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        sv_load_in |=> (state_q == ST_IDLE))
        else $error("vector load did not restart");
    a_shift_fill: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q == ST_RUN && core_done_in && !sv_load_in && mode_q == CFBW_ENC)
        |=> ((sr_q & $past(kmask)) == ($past(xor_res) & $past(kmask))))
        else $error("cipher bits not fed back");
    a_dec_feedback: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q == ST_RUN && core_done_in && !sv_load_in && mode_q == CFBW_DEC)
        |=> ((sr_q & $past(kmask)) == ($past(data_q) & $past(kmask))))
        else $error("received cipher not fed back");
    a_one_run: assert property (@(posedge clk_in) disable iff (reset_in)
        char_take |=> core_start_out ##1 !core_start_out)
        else $error("core not run once per character");
    a_hide_mac: assert property (@(posedge clk_in) disable iff (reset_in)
        (is_mac && state_q == ST_RUN && !last_q) |=> !res_valid_out)
        else $error("intermediate cipher output in mac mode");
    c_enc_char: cover property (@(posedge clk_in) mode_q == CFBW_ENC && res_valid_out);
    c_dec_char: cover property (@(posedge clk_in) mode_q == CFBW_DEC && res_valid_out);
    c_mac_ok: cover property (@(posedge clk_in) mac_done_out && mac_ok_out);
    c_restart: cover property (@(posedge clk_in) sv_load_in && state_q == ST_RUN);
endmodule : cfbw_top

/* dv/cfbw_core_model.sv */
// Purpose: behavioural stand-in for the 64-bit block cipher core
// Assumes: one block in flight; start is a one-cycle pulse
// Notes: answer delay is set per block by the bench, 0 to 15 extra cycles
module cfbw_core_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // request from the wrapper
    input wire logic start_in,
    input wire logic [63:0] block_in,
    input wire logic decrypt_in,
    input wire logic [3:0] delay_in,
    // answer
    output logic done_out,
    output logic [63:0] result_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // keyed mixing stand-in
    logic busy_q;
    logic [3:0] cnt_q;
    logic [63:0] hold_q;

    function automatic logic [63:0] mix(input logic [63:0] b);
        mix = {b[40:0], b[63:41]} ^ {b[15:0], b[63:16]} ^ 64'h5a3c96e10f87d2b4;
    endfunction : mix

    // ==========================================================
    // start and done handshake
    always_ff @(posedge clk_in)
    begin
        done_out <= 1'b0;
        // result is meaningless outside done, so it toggles every cycle
        result_out <= ~result_out;
        if (reset_in)
        begin
            busy_q <= 1'b0;
            result_out <= 64'h0f0f0f0f0f0f0f0f;
        end
        else if (start_in && !busy_q)
        begin
            busy_q <= 1'b1;
            cnt_q <= delay_in;
            // a reverse-direction request gives a visibly wrong block
            hold_q <= decrypt_in ? ~mix(block_in) : mix(block_in);
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0)
            begin
                busy_q <= 1'b0;
                done_out <= 1'b1;
                result_out <= hold_q;
            end
        end
    end
endmodule : cfbw_core_model

/* dv/cfb_mode_wrapper_test.sv */
// Purpose: self-checking bench for the cipher feedback mode wrapper
// Assumes: core model answers after a random delay of 0 to 5 cycles, a fixed 8 for the restart case
// Notes: expectations come from a reference input register kept here
module cfb_mode_wrapper_test
    import cfbw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    logic clk_in = 1'b0, reset_in = 1'b1, sv_load_in = 1'b0, char_valid_in = 1'b0;
    logic char_last_in = 1'b0, bad_mac = 1'b0, bad_mid = 1'b0;
    logic [1:0] mode_in = 2'h0, mode_ref = 2'h0;
    logic [6:0] k_in = 7'h08, char_width_in = 7'h08;
    logic [63:0] starting_vector_in = 64'h0, char_data_in = 64'h0, mac_expected_in = 64'h0;
    logic [63:0] mid_received_in = 64'h0, mid_expected_in = 64'h0;
    logic char_ready_out, res_valid_out, mac_done_out, mac_ok_out, core_done_in;
    logic core_start_out, core_decrypt_out;
    logic [63:0] res_data_out, core_block_out, core_result_in;
    logic [3:0] core_delay = 4'h0;
    logic [63:0] ref_q, last_block, mac_ref, got, pt_g, sv;
    logic [63:0] pts [80];
    logic [63:0] cts [80];
    int n_errors = 0, comparisons = 0, n_starts = 0, s0 = 0, k_ref = 8, i, j, kk;
    int k_list [6] = '{1, 5, 8, 63, 64, 2};

    cfbw_top cfbw_top_inst (.clk_in(clk_in), .reset_in(reset_in), .mode_in(mode_in),
        .k_in(k_in), .sv_load_in(sv_load_in), .starting_vector_in(starting_vector_in),
        .char_valid_in(char_valid_in), .char_data_in(char_data_in),
        .char_width_in(char_width_in), .char_last_in(char_last_in),
        .char_ready_out(char_ready_out), .res_valid_out(res_valid_out),
        .res_data_out(res_data_out), .mac_expected_in(mac_expected_in),
        .mid_received_in(mid_received_in), .mid_expected_in(mid_expected_in),
        .mac_done_out(mac_done_out), .mac_ok_out(mac_ok_out), .core_start_out(core_start_out),
        .core_block_out(core_block_out), .core_decrypt_out(core_decrypt_out),
        .core_done_in(core_done_in), .core_result_in(core_result_in));

    cfbw_core_model cfbw_core_model_inst (.clk_in(clk_in), .reset_in(reset_in),
        .start_in(core_start_out), .block_in(core_block_out), .decrypt_in(core_decrypt_out),
        .delay_in(core_delay), .done_out(core_done_in), .result_out(core_result_in));

    initial
    begin
        forever #12.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        if (core_start_out === 1'b1)
        begin
            n_starts = n_starts + 1;
            last_block = core_block_out;
            check(64'(core_decrypt_out), 64'h0);
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [63:0] model_mix(input logic [63:0] b);
        model_mix = {b[40:0], b[63:41]} ^ {b[15:0], b[63:16]} ^ 64'h5a3c96e10f87d2b4;
    endfunction : model_mix

    function automatic logic sig(input int sel);
        case (sel)
            0: sig = char_ready_out;
            1: sig = res_valid_out;
            2: sig = mac_done_out;
            default: sig = char_ready_out && (n_starts != s0);
        endcase
    endfunction : sig

    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick

    task automatic wait_sig(input int sel);
        int t;
        t = 0;
        while (sig(sel) !== 1'b1)
        begin
            tick(1);
            t++;
            if (t > 400)
            begin
                n_errors++;
                test_done();
            end
        end
    endtask : wait_sig

    task automatic load(input logic [1:0] mode, input int k, input logic [63:0] v);
        mode_in = mode;
        k_in = 7'(k);
        starting_vector_in = v;
        sv_load_in = 1'b1;
        mode_ref = mode;
        k_ref = k;
        ref_q = v;
        tick(1);
        sv_load_in = 1'b0;
    endtask : load

    // reference step first, then one handshake and its answer
    task automatic send_char(input logic [63:0] d, input int w, input logic last);
        logic [63:0] m, out, blk, res;
        logic cfb_end;
        m = (64'h1 << k_ref) - 64'h1;
        pt_g = d & ((64'h1 << w) - 64'h1) & m;
        blk = (mode_ref == CFBW_MAC_CBC) ? ref_q ^ pt_g : ref_q;
        out = model_mix(blk);
        res = (pt_g ^ (out >> (64 - k_ref))) & m;
        if (mode_ref == CFBW_MAC_CBC)
            ref_q = out;
        else
            ref_q = (ref_q << k_ref) | ((mode_ref == CFBW_DEC) ? pt_g : res);
        mac_ref = ((mode_ref == CFBW_MAC_CBC) ? out : model_mix(ref_q)) >> (64 - k_ref);
        cfb_end = last && (mode_ref == CFBW_MAC_CFB);
        s0 = n_starts;
        core_delay = 4'($urandom_range(5));
        char_data_in = d;
        char_width_in = 7'(w);
        char_last_in = last;
        mac_expected_in = mac_ref ^ {63'h0, bad_mac};
        mid_received_in = mid_expected_in ^ {63'h0, bad_mid};
        char_valid_in = 1'b1;
        wait_sig(0);
        tick(1);
        char_valid_in = 1'b0;
        if (mode_ref == CFBW_ENC || mode_ref == CFBW_DEC)
        begin
            wait_sig(1);
            got = res_data_out & m;
            check(got, res);
        end
        else if (last)
        begin
            wait_sig(2);
            check(64'(mac_ok_out), 64'(!(bad_mac || bad_mid)));
        end
        else
            wait_sig(3);
        check(64'(n_starts - s0), cfb_end ? 64'h2 : 64'h1);
        check(last_block, cfb_end ? ref_q : blk);
        tick(1);
    endtask : send_char

    // ==========================================================
    // scenarios
    initial
    begin
        void'($urandom(32'h09108fcf));
        tick(6);
        check({61'h0, res_valid_out, mac_done_out, core_start_out}, 64'h0);
        tick(6);
        reset_in = 1'b0;
        k_list[5] = 1 + $urandom_range(62);
        for (j = 0; j < 6; j++)
        begin
            kk = k_list[j];
            sv = {16'h0, 48'({$urandom(), $urandom()})};
            load(CFBW_ENC, kk, sv);
            for (i = 0; i < 6 + 64 / kk; i++)
            begin
                send_char({$urandom(), $urandom()}, 1 + $urandom_range(kk - 1), 1'b0);
                pts[i] = pt_g;
                cts[i] = got;
            end
            // full k width on the decrypt end, one ciphertext bit flipped on the way
            load(CFBW_DEC, kk, sv);
            for (i = 0; i < 6 + 64 / kk; i++)
            begin
                send_char(cts[i] ^ ((i == 2) ? 64'h1 : 64'h0), kk, 1'b0);
                if (i == 2)
                    check(got, pts[i] ^ 64'h1);
                else if (i < 2 || i > 4 + 64 / kk)
                    check(got, pts[i]);
            end
        end
        // restart while a character is in flight: no answer, fresh register
        load(CFBW_ENC, 8, sv);
        core_delay = 4'h8;
        char_valid_in = 1'b1;
        wait_sig(0);
        tick(1);
        char_valid_in = 1'b0;
        tick(3);
        sv = ~sv;
        load(CFBW_ENC, 8, sv);
        kk = 0;
        for (i = 0; i < 15; i++)
        begin
            if (res_valid_out === 1'b1)
                kk++;
            tick(1);
        end
        check(64'(kk), 64'h0);
        send_char({$urandom(), $urandom()}, 8, 1'b0);
        // mac modes: matching, wrong code, wrong identifier
        for (j = 0; j < 6; j++)
        begin
            bad_mac = (j % 3 == 1);
            bad_mid = (j % 3 == 2);
            mid_expected_in = {$urandom(), $urandom()};
            load((j < 3) ? CFBW_MAC_CFB : CFBW_MAC_CBC, (j < 3) ? 24 : 64, mid_expected_in);
            // fixed closing data; chaining starts from an all-zero block
            for (i = 0; i < 4; i++)
                send_char((i == 3 || (i == 0 && j >= 3)) ? 64'h0 : {$urandom(), $urandom()},
                    64, i == 3);
        end
        test_done();
    end
endmodule : cfb_mode_wrapper_test
